// ### shared/zvr_pkg.sv
/*
 * Constants for the video port routing control block: register offsets,
 * field positions, reset values and the register space selector.
 * Assumes a two-socket card controller with one function per socket.
 */
package zvr_pkg;

	// Number of card sockets and card address width.
	localparam int NUM_SOCKETS = 2;
	localparam int ADDR_W      = 26;
	localparam int LOW_ADDR_W  = 4;

	// Register space selector on the register port.
	typedef enum logic [0:0] {
		ZVR_SPACE_CFG  = 1'b0,
		ZVR_SPACE_SOCK = 1'b1
	} zvr_space_e;

	// Per-function configuration space, byte wide.
	localparam logic [7:0] OFF_CARD_CONTROL       = 8'h91;
	localparam logic [7:0] OFF_DIAGNOSTIC_CONTROL = 8'h93;

	// Per-socket socket register space, word wide.
	localparam logic [7:0] OFF_SOCKET_PRESENT_STATE = 8'h08;
	localparam logic [7:0] OFF_SOCKET_FORCE_EVENT   = 8'h0C;
	localparam logic [7:0] OFF_SOCKET_CONTROL       = 8'h10;

	// Card control fields.
	localparam int BIT_LEGACY_VIDEO_PORT_ON = 6;
	localparam int BIT_PORT_PRIORITY_B      = 5;

	// Diagnostic control field.
	localparam int BIT_STD_VIDEO_MODEL_DISABLE = 0;

	// Present state and force event fields.
	localparam int BIT_PLATFORM_VIDEO_CAPABLE       = 27;
	localparam int BIT_FORCE_PLATFORM_VIDEO_CAPABLE = 27;

	// Socket control fields.
	localparam int BIT_VIDEO_IN_USE_FLAG       = 11;
	localparam int BIT_STD_VIDEO_MODEL_PRESENT = 10;
	localparam int BIT_SOCKET_VIDEO_ON         = 9;

	// Reset values.
	localparam logic [7:0] RST_CARD_CONTROL       = 8'h00;
	localparam logic [7:0] RST_DIAGNOSTIC_CONTROL = 8'h00;
	localparam logic       RST_PLATFORM_CAPABLE   = 1'b0;
	localparam logic       RST_SOCKET_VIDEO_ON    = 1'b0;

endpackage : zvr_pkg

// ### shared/zvr_video_if.sv
/*
 * Carrier between the register side of the block and the video source
 * arbiter. Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface zvr_video_if;
	logic [1:0] video_en;
	logic       port_pri_b;
	logic       sel_a_n;
	logic       sel_b_n;
	logic       any_active;

	modport ctl (
		output video_en,
		output port_pri_b,
		input  sel_a_n,
		input  sel_b_n,
		input  any_active
	);

	modport arb (
		input  video_en,
		input  port_pri_b,
		output sel_a_n,
		output sel_b_n,
		output any_active
	);
endinterface : zvr_video_if

`default_nettype wire

// ### logic/zvr_video_arbiter.sv
/*
 * Video source arbiter: turns the per-socket video enables and the
 * priority setting into registered select and status outputs.
 * Assumes enables are on the same clock and already settled.
 */
`timescale 1ns/1ns
`default_nettype none

module zvr_video_arbiter (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// Arbitration carrier
	zvr_video_if.arb  vid
);

	logic pick_a;
	logic pick_b;

	// Socket B wins when enabled and either preferred or alone.
	always_comb begin
		pick_b = vid.video_en[1] & (vid.port_pri_b | ~vid.video_en[0]);
		pick_a = vid.video_en[0] & ~pick_b;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			vid.sel_a_n    <= 1'b1;
			vid.sel_b_n    <= 1'b1;
			vid.any_active <= 1'b0;
		end else begin
			// Only one pick can be true, so both selects never go low.
			vid.sel_a_n    <= ~pick_a;
			vid.sel_b_n    <= ~pick_b;
			vid.any_active <= |vid.video_en;
		end
	end

endmodule // zvr_video_arbiter

`default_nettype wire

// ### logic/zvr_video_port_routing_control.sv
/*
 * Video port routing control for a two-socket card controller: per-socket
 * legacy and standardized video enables, card address float, and the
 * select and status outputs for external three-state bus drivers.
 * Assumes a simple register port on the host bus clock, with accesses
 * issued by logic on the same clock, and card address values from the
 * card interface on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module zvr_video_port_routing_control #(
	parameter int NUM_SOCKETS = zvr_pkg::NUM_SOCKETS,
	parameter int ADDR_W      = zvr_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   sys_rst_in,
	// Register port
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	input  wire logic                   reg_space_in,
	input  wire logic                   reg_socket_in,
	input  wire logic [7:0]             reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	output var  logic [31:0]            reg_rdata_out,
	output var  logic                   reg_rvalid_out,
	// Card address lines, one row per socket
	input  wire logic [1:0][ADDR_W-1:0] card_addr_in,
	output var  logic [1:0][ADDR_W-1:0] card_addr_out,
	output var  logic [1:0][ADDR_W-1:0] card_addr_oe_n_out,
	// Video routing outputs
	output wire logic                   socket_a_video_select_n_out,
	output wire logic                   socket_b_video_select_n_out,
	output wire logic                   any_video_active_out
);

	localparam int LW = zvr_pkg::LOW_ADDR_W;

	// Per-socket register state, plus the diagnostic register shared by both sockets.
	logic [1:0][7:0] card_control;
	logic [1:0]      platform_video_capable;
	logic [1:0]      socket_video_on;
	logic [7:0]      diagnostic_control;

	// Derived video state.
	logic            std_model_on;
	logic [1:0]      legacy_video_port_on;
	logic [1:0]      next_video_en;
	logic            video_in_use_flag;

	// Decoded writes.
	logic            wr_cfg;
	logic            wr_sock;

	zvr_video_if vid ();

	// True when an access targets the given space and offset.
	function automatic logic reg_hit(
		input logic       space,
		input logic [7:0] addr,
		input logic       want_space,
		input logic [7:0] want_addr
	);
		reg_hit = (space == want_space) && (addr == want_addr);
	endfunction

	assign wr_cfg  = reg_wr_in && (reg_space_in == zvr_pkg::ZVR_SPACE_CFG);
	assign wr_sock = reg_wr_in && (reg_space_in == zvr_pkg::ZVR_SPACE_SOCK);

	// The diagnostic register is shared; either function may write it.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			diagnostic_control <= zvr_pkg::RST_DIAGNOSTIC_CONTROL;
		end else if (wr_cfg && reg_hit(reg_space_in, reg_addr_in,
				zvr_pkg::ZVR_SPACE_CFG,
				zvr_pkg::OFF_DIAGNOSTIC_CONTROL)) begin
			diagnostic_control <= reg_wdata_in[7:0];
		end
	end

	assign std_model_on =
		~diagnostic_control[zvr_pkg::BIT_STD_VIDEO_MODEL_DISABLE];

	genvar s;
	generate
		for (s = 0; s < NUM_SOCKETS; s++) begin : g_sock
			logic sel_me;

			assign sel_me = (reg_socket_in == 1'(s));

			// Card control: legacy enable and priority live here.
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					card_control[s] <= zvr_pkg::RST_CARD_CONTROL;
				end else if (wr_cfg && sel_me && reg_hit(reg_space_in,
						reg_addr_in, zvr_pkg::ZVR_SPACE_CFG,
						zvr_pkg::OFF_CARD_CONTROL)) begin
					card_control[s] <= reg_wdata_in[7:0];
				end
			end

			// The support flag is only ever set; reset alone clears it.
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					platform_video_capable[s] <= zvr_pkg::RST_PLATFORM_CAPABLE;
				end else if (wr_sock && sel_me && reg_hit(reg_space_in,
						reg_addr_in, zvr_pkg::ZVR_SPACE_SOCK,
						zvr_pkg::OFF_SOCKET_FORCE_EVENT) &&
						reg_wdata_in[
						zvr_pkg::BIT_FORCE_PLATFORM_VIDEO_CAPABLE]) begin
					platform_video_capable[s] <= 1'b1;
				end
			end

			// Socket control enable bit, writable per socket.
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					socket_video_on[s] <= zvr_pkg::RST_SOCKET_VIDEO_ON;
				end else if (wr_sock && sel_me && reg_hit(reg_space_in,
						reg_addr_in, zvr_pkg::ZVR_SPACE_SOCK,
						zvr_pkg::OFF_SOCKET_CONTROL)) begin
					socket_video_on[s] <=
						reg_wdata_in[zvr_pkg::BIT_SOCKET_VIDEO_ON];
				end
			end

			assign legacy_video_port_on[s] =
				card_control[s][zvr_pkg::BIT_LEGACY_VIDEO_PORT_ON];

			// The legacy path stays live even with the new model on.
			assign next_video_en[s] = legacy_video_port_on[s] |
				(std_model_on & socket_video_on[s]);

			// Card address lines pass through one register stage.
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					card_addr_out[s] <= '0;
				end else begin
					card_addr_out[s] <= card_addr_in[s];
				end
			end

			// Upper lines float in video mode; the low nibble keeps
			// driving so card configuration registers stay reachable.
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					card_addr_oe_n_out[s] <= '0;
				end else begin
					card_addr_oe_n_out[s][ADDR_W-1:LW] <=
						{(ADDR_W-LW){next_video_en[s]}};
					card_addr_oe_n_out[s][LW-1:0] <= '0;
				end
			end
		end
	endgenerate

	assign video_in_use_flag = |next_video_en;

	// Priority is taken from the socket A function's card control.
	assign vid.video_en   = next_video_en;
	assign vid.port_pri_b = card_control[0][zvr_pkg::BIT_PORT_PRIORITY_B];

	zvr_video_arbiter u_arbiter (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.vid        (vid.arb)
	);

	assign socket_a_video_select_n_out = vid.sel_a_n;
	assign socket_b_video_select_n_out = vid.sel_b_n;
	assign any_video_active_out        = vid.any_active;

	// Read mux; unmapped and write-only offsets read as zero.
	logic [31:0] next_rdata;
	logic        rsock;

	always_comb begin
		next_rdata = 32'h0000_0000;
		rsock      = reg_socket_in;
		if (reg_hit(reg_space_in, reg_addr_in, zvr_pkg::ZVR_SPACE_CFG,
				zvr_pkg::OFF_CARD_CONTROL)) begin
			next_rdata[7:0] = card_control[rsock];
		end else if (reg_hit(reg_space_in, reg_addr_in,
				zvr_pkg::ZVR_SPACE_CFG,
				zvr_pkg::OFF_DIAGNOSTIC_CONTROL)) begin
			next_rdata[7:0] = diagnostic_control;
		end else if (reg_hit(reg_space_in, reg_addr_in,
				zvr_pkg::ZVR_SPACE_SOCK,
				zvr_pkg::OFF_SOCKET_PRESENT_STATE)) begin
			next_rdata[zvr_pkg::BIT_PLATFORM_VIDEO_CAPABLE] =
				platform_video_capable[rsock];
		end else if (reg_hit(reg_space_in, reg_addr_in,
				zvr_pkg::ZVR_SPACE_SOCK,
				zvr_pkg::OFF_SOCKET_CONTROL)) begin
			next_rdata[zvr_pkg::BIT_VIDEO_IN_USE_FLAG] =
				video_in_use_flag;
			next_rdata[zvr_pkg::BIT_STD_VIDEO_MODEL_PRESENT] =
				std_model_on;
			next_rdata[zvr_pkg::BIT_SOCKET_VIDEO_ON] =
				socket_video_on[rsock];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out  <= 32'h0000_0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= next_rdata;
			end
		end
	end

endmodule // zvr_video_port_routing_control

`default_nettype wire

// ### verif/zvr_checker.sv
/*
 * Assertion checker for the video port routing control block.
 * Assumes it sees only the top module's ports, bound in at the foot.
 */
`timescale 1ns/1ns
`default_nettype none

module zvr_checker #(
	parameter int NUM_SOCKETS = 2,
	parameter int ADDR_W      = 26
) (
	// Clock and reset
	input wire logic                   clk_in,
	input wire logic                   sys_rst_in,
	// Register port
	input wire logic                   reg_wr_in,
	input wire logic                   reg_rd_in,
	input wire logic                   reg_space_in,
	input wire logic                   reg_socket_in,
	input wire logic [7:0]             reg_addr_in,
	input wire logic [31:0]            reg_wdata_in,
	input wire logic [31:0]            reg_rdata_out,
	input wire logic                   reg_rvalid_out,
	// Card address lines and video outputs
	input wire logic [1:0][ADDR_W-1:0] card_addr_in,
	input wire logic [1:0][ADDR_W-1:0] card_addr_out,
	input wire logic [1:0][ADDR_W-1:0] card_addr_oe_n_out,
	input wire logic                   socket_a_video_select_n_out,
	input wire logic                   socket_b_video_select_n_out,
	input wire logic                   any_video_active_out
);
	wire logic sa = socket_a_video_select_n_out;
	wire logic sb = socket_b_video_select_n_out;
	wire logic st = any_video_active_out;

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	a_sel_exclusive: assert property (sa || sb)
		else $error("both select outputs low");
	a_status_match: assert property (st == (!sa || !sb))
		else $error("status does not match selects");
	a_low_lines: assert property (card_addr_oe_n_out[0][3:0] == 4'h0 && card_addr_oe_n_out[1][3:0] == 4'h0)
		else $error("low address lines not driven");
	a_float_whole: assert property ((&card_addr_oe_n_out[0][ADDR_W-1:4]) == (|card_addr_oe_n_out[0][ADDR_W-1:4]))
		else $error("upper address lines float in part");
	a_float_status: assert property (card_addr_oe_n_out[0][4] || card_addr_oe_n_out[1][4] |-> st)
		else $error("lines float with no video active");
	a_addr_follow: assert property (!$past(sys_rst_in) |-> card_addr_out == $past(card_addr_in))
		else $error("card address not passed on");
	a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read not answered next cycle");
	a_no_stray_valid: assert property (reg_rvalid_out |-> $past(reg_rd_in))
		else $error("read valid without a read");
	a_legacy_on: assert property (reg_wr_in && !reg_space_in && !reg_socket_in && reg_addr_in == 8'h91 && reg_wdata_in[6] |-> ##2 st && card_addr_oe_n_out[0][4])
		else $error("legacy enable had no effect");
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=> sa && sb && !st)
		else $error("video outputs active after reset");

	c_pick_a: cover property (!sa);
	c_pick_b: cover property (!sb);
	c_read: cover property (reg_rvalid_out);
endmodule // zvr_checker

bind zvr_video_port_routing_control zvr_checker #(
	.NUM_SOCKETS(NUM_SOCKETS),
	.ADDR_W(ADDR_W)
) chk_u (
	.clk_in, .sys_rst_in, .reg_wr_in, .reg_rd_in, .reg_space_in,
	.reg_socket_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
	.reg_rvalid_out, .card_addr_in, .card_addr_out, .card_addr_oe_n_out,
	.socket_a_video_select_n_out, .socket_b_video_select_n_out,
	.any_video_active_out
);

`default_nettype wire

// ### verif/zvr_bus_drivers.sv
/*
 * Model of the external three-state bus drivers that feed the graphics
 * controller. Assumes selects and status come straight from the block.
 */
`timescale 1ns/1ns
`default_nettype none

module zvr_bus_drivers (
	// Enables from the block, all active low but status
	input  wire logic       sel_a_n_in,
	input  wire logic       sel_b_n_in,
	input  wire logic       stat_in,
	// Video streams and the merged result
	input  wire logic [7:0] a_in,
	input  wire logic [7:0] b_in,
	input  wire logic [7:0] aux_in,
	output var  logic [7:0] gfx_out
);
	// The third source is enabled by a low status. Contention shows as a
	// pattern that no source sends, so it can never pass for a match.
	always_comb begin
		case ({sel_a_n_in, sel_b_n_in, stat_in})
			3'b011: gfx_out = a_in;
			3'b101: gfx_out = b_in;
			3'b110: gfx_out = aux_in;
			default: gfx_out = ~(a_in ^ b_in);
		endcase
	end
endmodule // zvr_bus_drivers

`default_nettype wire

// ### verif/zvr_video_port_routing_control_bench.sv
/*
 * Self-checking bench for the video port routing control block.
 * Assumes the checker is bound in and the bus driver model is compiled.
 */
`timescale 1ns/1ns
`default_nettype none

module zvr_video_port_routing_control_bench;
	localparam logic [7:0]  A_DAT = 8'h5A;
	localparam logic [7:0]  B_DAT = 8'hC3;
	localparam logic [7:0]  X_DAT = 8'h3C;
	localparam logic [25:0] FLT   = 26'h3FFFFF0;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        reg_space_in = 1'b0;
	logic        reg_socket_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic [31:0] reg_rdata_out;
	logic        reg_rvalid_out;
	logic [1:0][25:0] card_addr_in = {26'h2AAAAAA, 26'h1555555};
	logic [1:0][25:0] card_addr_out;
	logic [1:0][25:0] oe_n;
	logic        sa;
	logic        sb;
	logic        st;
	logic [7:0]  gfx;
	int          failures = 0;
	int          compares = 0;

	always #2 clk_in = ~clk_in;

	zvr_video_port_routing_control dut_u (
		.clk_in, .sys_rst_in, .reg_wr_in, .reg_rd_in, .reg_space_in,
		.reg_socket_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
		.reg_rvalid_out, .card_addr_in, .card_addr_out,
		.card_addr_oe_n_out(oe_n), .socket_a_video_select_n_out(sa),
		.socket_b_video_select_n_out(sb), .any_video_active_out(st)
	);

	zvr_bus_drivers drv_u (
		.sel_a_n_in(sa), .sel_b_n_in(sb), .stat_in(st), .a_in(A_DAT),
		.b_in(B_DAT), .aux_in(X_DAT), .gfx_out(gfx)
	);

	task step;
		@(posedge clk_in);
		#1;
	endtask

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task wr(input logic sp, sk, input logic [7:0] a, input logic [31:0] d);
		step;
		reg_wr_in = 1'b1;
		reg_space_in = sp;
		reg_socket_in = sk;
		reg_addr_in = a;
		reg_wdata_in = d;
		step;
		reg_wr_in = 1'b0;
	endtask

	task rc(input logic sp, sk, input logic [7:0] a, input logic [31:0] e);
		step;
		reg_rd_in = 1'b1;
		reg_space_in = sp;
		reg_socket_in = sk;
		reg_addr_in = a;
		step;
		reg_rd_in = 1'b0;
		chk(64'(reg_rvalid_out), 64'h1);
		chk(64'(reg_rdata_out), 64'(e));
	endtask

	// Outputs settle one edge after the last enable write has landed.
	task vid(input logic pri, ea, eb);
		logic pa;
		logic pb;
		pb = eb & (pri | !ea);
		pa = ea & !pb;
		step;
		chk({1'b0, oe_n, sa, sb, st, gfx}, {1'b0, eb ? FLT : 26'h0,
			ea ? FLT : 26'h0, !pa, !pb, ea | eb,
			pa ? A_DAT : (pb ? B_DAT : X_DAT)});
		chk(64'(card_addr_out), 64'(card_addr_in));
	endtask

	task t_reset;
		vid(1'b0, 1'b0, 1'b0);
		rc(1'b1, 1'b0, 8'h10, 32'h00000400);
		rc(1'b1, 1'b0, 8'h08, 32'h00000000);
	endtask

	task t_table;
		for (int i = 0; i < 8; i++) begin
			wr(1'b0, 1'b0, 8'h91, {25'h0, i[1], i[2], 5'h00});
			wr(1'b0, 1'b1, 8'h91, {25'h0, i[0], 6'h00});
			vid(i[2], i[1], i[0]);
		end
		wr(1'b0, 1'b0, 8'h91, 32'h0);
		wr(1'b0, 1'b1, 8'h91, 32'h0);
	endtask

	task t_std;
		wr(1'b1, 1'b1, 8'h10, 32'h0000FFFF);
		vid(1'b0, 1'b0, 1'b1);
		rc(1'b1, 1'b1, 8'h10, 32'h00000E00);
		rc(1'b1, 1'b0, 8'h10, 32'h00000C00);
		wr(1'b0, 1'b0, 8'h93, 32'h00000001);
		vid(1'b0, 1'b0, 1'b0);
		rc(1'b1, 1'b1, 8'h10, 32'h00000200);
		wr(1'b0, 1'b0, 8'h91, 32'h00000040);
		vid(1'b0, 1'b1, 1'b0);
		wr(1'b0, 1'b0, 8'h91, 32'h0);
		wr(1'b0, 1'b0, 8'h93, 32'h0);
		wr(1'b1, 1'b1, 8'h10, 32'h0);
	endtask

	task t_support;
		wr(1'b1, 1'b0, 8'h0C, 32'h08000000);
		wr(1'b1, 1'b1, 8'h0C, 32'hF7FFFFFF);
		rc(1'b1, 1'b0, 8'h08, 32'h08000000);
		rc(1'b1, 1'b1, 8'h08, 32'h00000000);
		wr(1'b1, 1'b0, 8'h08, 32'h0);
		rc(1'b1, 1'b0, 8'h08, 32'h08000000);
		rc(1'b1, 1'b0, 8'h0C, 32'h00000000);
		rc(1'b1, 1'b0, 8'h14, 32'h00000000);
	endtask

	task close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		t_reset;
		t_table;
		t_std;
		t_support;
		close_out;
	end

	// The tests need well under a thousand cycles.
	initial begin
		#20000;
		failures++;
		close_out;
	end
endmodule // zvr_video_port_routing_control_bench

`default_nettype wire
